// File: verilog/bdp_dio_top.sv
// Banked 8-bit digital I/O ports with global enable and level interrupts
//
// Behaviour
// - Operations stay disabled after reset until software enables them.
// - After reset every port is input and no pin is driven.
// - Output latch content is meaningless until software loads it.
// - Global enable low disables all port operations; high enables them.
// - Input port samples pins; a host read returns those levels.
// - Output port read returns its output latch value.
// - Writing an input port updates only its latch; pins stay undriven.
// - Switching a port to output drives the latched value at once.
// - Port 2 bits 0 to 3 are four separate interrupt sources.
// - Interrupt is level triggered, active high after polarity adjustment.
// - Each source has programmable polarity: pass through or invert.
// - Service routine reads source states, compares, flips polarity, stores.
// - Eighteen or twenty-one 8-bit ports, each independently in or out.
// - Each source has its own enable; all disabled after reset.
module bdp_dio_top
#(
   parameter int NUM_PORTS = bdp_pkg::PORTS_DEF
)
(
   input  wire logic                                 core_clk_in,
   input  wire logic                                 reset_n_in,
   input  wire logic                                 clk_en_in,
   input  wire logic                                 ops_en_we_in,
   input  wire logic                                 ops_en_in,
   output logic                                      ops_en_out,
   input  wire logic [bdp_pkg::SEL_W-1:0]            port_sel_in,
   input  wire logic                                 data_we_in,
   input  wire logic [bdp_pkg::PORT_W-1:0]           data_in,
   input  wire logic                                 data_re_in,
   output logic      [bdp_pkg::PORT_W-1:0]           rdata_out,
   output logic                                      rvalid_out,
   input  wire logic                                 dir_we_in,
   input  wire logic [NUM_PORTS-1:0]                 dir_in,
   output logic      [NUM_PORTS-1:0]                 dir_out,
   input  wire logic                                 irq_en_we_in,
   input  wire logic [bdp_pkg::IRQ_N-1:0]            irq_en_in,
   input  wire logic                                 irq_pol_we_in,
   input  wire logic [bdp_pkg::IRQ_N-1:0]            irq_pol_in,
   output logic      [bdp_pkg::IRQ_N-1:0]            irq_level_out,
   output logic                                      irq_out,
   input  wire logic [NUM_PORTS*bdp_pkg::PORT_W-1:0] pin_in,
   output logic      [NUM_PORTS*bdp_pkg::PORT_W-1:0] pin_out,
   output logic      [NUM_PORTS-1:0]                 pin_oe_n_out
);
   // ***************************************************************
   // Elaboration checks
   // ***************************************************************
   // Port 2 must exist for the interrupt sources; PORTS_MAX caps the count
   generate
      if (NUM_PORTS <= bdp_pkg::IRQ_PORT || NUM_PORTS > bdp_pkg::PORTS_MAX)
      begin : g_bad_ports
         $error("NUM_PORTS out of supported range");
      end
   endgenerate

   // ***************************************************************
   // Global operations enable
   // ***************************************************************
   logic ops_en_r, ops_en_nxt;

   always_comb
   begin
      ops_en_nxt = ops_en_we_in ? ops_en_in : ops_en_r;
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ops_en_r <= bdp_pkg::OPS_EN_RST;
      end
      else if (clk_en_in)
      begin
         ops_en_r <= ops_en_nxt;
      end
   end

   assign ops_en_out = ops_en_r;

   // ***************************************************************
   // Port slices
   // ***************************************************************
   logic                       sel_ok;
   logic [bdp_pkg::PORT_W-1:0] latch_a  [NUM_PORTS];
   logic [bdp_pkg::PORT_W-1:0] sample_a [NUM_PORTS];
   logic [NUM_PORTS-1:0]       dir_v;

   assign sel_ok = int'(port_sel_in) < NUM_PORTS;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++)
      begin : g_port
         bdp_port_slice u_slice
         (
            .clk_in        (core_clk_in),
            .reset_n_in    (reset_n_in),
            .clk_en_in     (clk_en_in),
            .ops_en_in     (ops_en_r),
            .ops_en_nxt_in (ops_en_nxt),
            .data_we_in    (data_we_in && sel_ok && int'(port_sel_in) == gi),
            .data_in       (data_in),
            .dir_we_in     (dir_we_in),
            .dir_in        (dir_in[gi]),
            .pin_in        (pin_in[gi*bdp_pkg::PORT_W +: bdp_pkg::PORT_W]),
            .latch_out     (latch_a[gi]),
            .sample_out    (sample_a[gi]),
            .dir_out       (dir_v[gi]),
            .pin_out       (pin_out[gi*bdp_pkg::PORT_W +: bdp_pkg::PORT_W]),
            .pin_oe_n_out  (pin_oe_n_out[gi])
         );
      end
   endgenerate

   assign dir_out = dir_v;

   // ***************************************************************
   // Host read path
   // ***************************************************************
   logic [bdp_pkg::PORT_W-1:0] rdata_r, rdata_nxt;
   logic                       rvalid_r, rvalid_nxt;

   always_comb
   begin
      rvalid_nxt = data_re_in;
      rdata_nxt  = rdata_r;
      if (data_re_in)
      begin
         // Disabled or unmapped reads answer zero rather than stale data
         if (!ops_en_r || !sel_ok)
         begin
            rdata_nxt = bdp_pkg::DATA_RST;
         end
         else if (dir_v[port_sel_in])
         begin
            rdata_nxt = latch_a[port_sel_in];
         end
         else
         begin
            rdata_nxt = sample_a[port_sel_in];
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rdata_r  <= bdp_pkg::DATA_RST;
         rvalid_r <= 1'b0;
      end
      else if (clk_en_in)
      begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign rdata_out  = rdata_r;
   assign rvalid_out = rvalid_r;

   // ***************************************************************
   // Interrupt sources on port 2
   // ***************************************************************
   logic [bdp_pkg::IRQ_N-1:0] irq_src;
   logic [bdp_pkg::IRQ_N-1:0] irq_en_v;
   logic [bdp_pkg::IRQ_N-1:0] irq_pol_v;

   // Taken straight from the pins so sources work whatever the port direction
   assign irq_src = pin_in[bdp_pkg::IRQ_PORT*bdp_pkg::PORT_W + bdp_pkg::IRQ_BIT_LO
                           +: bdp_pkg::IRQ_N];

   bdp_irq_ctrl u_irq
   (
      .clk_in     (core_clk_in),
      .reset_n_in (reset_n_in),
      .clk_en_in  (clk_en_in),
      .en_we_in   (irq_en_we_in),
      .en_in      (irq_en_in),
      .pol_we_in  (irq_pol_we_in),
      .pol_in     (irq_pol_in),
      .src_in     (irq_src),
      .en_out     (irq_en_v),
      .pol_out    (irq_pol_v),
      .level_out  (irq_level_out),
      .irq_out    (irq_out)
   );

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   sequence s_dir_out_write(int p);
      clk_en_in && ops_en_r && ops_en_nxt && dir_we_in && dir_in[p];
   endsequence

   sequence s_driven_latch(int p);
      !pin_oe_n_out[p] && pin_out[p*bdp_pkg::PORT_W +: bdp_pkg::PORT_W] == latch_a[p];
   endsequence

   a_dis_no_drive: assert property (!ops_en_r |-> pin_oe_n_out == '1)
      else $error("pin driven while operations disabled");

   a_in_no_drive: assert property (
      ops_en_r && clk_en_in && !dir_we_in && dir_v == '0 |=> pin_oe_n_out == '1)
      else $error("input port drives its pins");

   a_dir_drive: assert property (
      s_dir_out_write(0) ##1 1'b1 |-> s_driven_latch(0))
      else $error("port not driving latch after switch to output");

   a_dis_wr_ignored: assert property (
      clk_en_in && !ops_en_r && data_we_in && sel_ok
      |=> latch_a[$past(port_sel_in)] == $past(latch_a[port_sel_in]))
      else $error("write changed latch while disabled");

   a_wr_latch: assert property (
      clk_en_in && ops_en_r && data_we_in && sel_ok
      |=> latch_a[$past(port_sel_in)] == $past(data_in))
      else $error("enabled write missed the latch");

   a_read_input: assert property (
      clk_en_in && ops_en_r && data_re_in && sel_ok && !dir_v[port_sel_in]
      |=> rvalid_out && rdata_out == $past(sample_a[port_sel_in]))
      else $error("input read does not return sampled pins");

   a_read_latch: assert property (
      clk_en_in && ops_en_r && data_re_in && sel_ok && dir_v[port_sel_in]
      |=> rvalid_out && rdata_out == $past(latch_a[port_sel_in]))
      else $error("output read does not return latch");

   a_irq_level: assert property (
      clk_en_in |=> irq_out == |(($past(irq_src) ^ $past(irq_pol_v)) & $past(irq_en_v)))
      else $error("interrupt request does not follow enabled levels");

   a_irq_hold: assert property (
      clk_en_in && |((irq_src ^ irq_pol_v) & irq_en_v) && !irq_en_we_in && !irq_pol_we_in
      ##1 clk_en_in && $stable(irq_src) |=> irq_out [*1] ##0 irq_out)
      else $error("level interrupt dropped while source held");

   a_src_level: assert property (
      clk_en_in |=> irq_level_out == ($past(irq_src) ^ $past(irq_pol_v)))
      else $error("source level ignores polarity");

   a_irq_en_off: assert property (irq_en_v == '0 && clk_en_in |=> !irq_out)
      else $error("request with all sources disabled");

   a_ops_gate: assert property (
      clk_en_in && !ops_en_r && dir_we_in |=> dir_v == $past(dir_v))
      else $error("direction changed while disabled");

   a_ops_load: assert property (
      clk_en_in && ops_en_we_in |=> ops_en_r == $past(ops_en_in))
      else $error("global enable not loaded");

   // Reads never stall, so a refused read still answers, with zero
   a_dis_read_zero: assert property (
      clk_en_in && data_re_in && (!ops_en_r || !sel_ok)
      |=> rvalid_out && rdata_out == bdp_pkg::DATA_RST)
      else $error("refused read returned data");

   a_rvalid_pulse: assert property (
      clk_en_in && !data_re_in |=> !rvalid_out)
      else $error("read valid without a read");

   a_oe_follows: assert property (
      pin_oe_n_out == ~(dir_v & {NUM_PORTS{ops_en_r}}))
      else $error("pin drive does not follow direction and enable");

   // Pins carry the latch even while undriven, so a switch needs no extra cycle
   generate
      for (gi = 0; gi < NUM_PORTS; gi++)
      begin : g_pin_chk
         a_pin_latch: assert property (
            pin_out[gi*bdp_pkg::PORT_W +: bdp_pkg::PORT_W] == latch_a[gi])
            else $error("port pins do not carry the latch");
      end
   endgenerate

   sequence s_src_armed(int s);
      clk_en_in && irq_en_v[s] && (irq_src[s] ^ irq_pol_v[s]);
   endsequence

   genvar gs;
   generate
      for (gs = 0; gs < bdp_pkg::IRQ_N; gs++)
      begin : g_src_chk
         a_src_raises: assert property (s_src_armed(gs) |=> irq_out)
            else $error("enabled active source did not raise request");
      end
   endgenerate

endmodule : bdp_dio_top

// File: shared/bdp_pkg.sv
// Constants shared by the banked digital I/O port block
package bdp_pkg;
   // ***************************************************************
   // Port geometry
   // ***************************************************************
   localparam int PORT_W        = 8;
   localparam int PORTS_DEF     = 18;
   localparam int PORTS_MAX     = 21;
   localparam int SEL_W         = 5;
   // ***************************************************************
   // Interrupt sources: low four bits of port 2
   // ***************************************************************
   localparam int IRQ_N         = 4;
   localparam int IRQ_PORT      = 2;
   localparam int IRQ_BIT_LO    = 0;
   // ***************************************************************
   // Values after reset
   // ***************************************************************
   localparam logic              OPS_EN_RST  = 1'b0;
   localparam logic              DIR_RST     = 1'b0;
   localparam logic              OE_N_RST    = 1'b1;
   localparam logic [PORT_W-1:0] LATCH_RST   = 8'h00;
   localparam logic [PORT_W-1:0] DATA_RST    = 8'h00;
   localparam logic [IRQ_N-1:0]  IRQ_EN_RST  = 4'h0;
   localparam logic [IRQ_N-1:0]  IRQ_POL_RST = 4'h0;
endpackage : bdp_pkg

// File: verilog/bdp_port_slice.sv
// One 8-bit bidirectional port: output latch, direction and pin drive
module bdp_port_slice
(
   input  wire logic                       clk_in,
   input  wire logic                       reset_n_in,
   input  wire logic                       clk_en_in,
   input  wire logic                       ops_en_in,
   input  wire logic                       ops_en_nxt_in,
   input  wire logic                       data_we_in,
   input  wire logic [bdp_pkg::PORT_W-1:0] data_in,
   input  wire logic                       dir_we_in,
   input  wire logic                       dir_in,
   input  wire logic [bdp_pkg::PORT_W-1:0] pin_in,
   output logic      [bdp_pkg::PORT_W-1:0] latch_out,
   output logic      [bdp_pkg::PORT_W-1:0] sample_out,
   output logic                            dir_out,
   output logic      [bdp_pkg::PORT_W-1:0] pin_out,
   output logic                            pin_oe_n_out
);
   logic [bdp_pkg::PORT_W-1:0] latch_r, latch_nxt;
   logic [bdp_pkg::PORT_W-1:0] sample_r, sample_nxt;
   logic                       dir_r, dir_nxt;
   logic [bdp_pkg::PORT_W-1:0] pin_r, pin_nxt;
   logic                       oe_n_r, oe_n_nxt;

   always_comb
   begin
      // Writes land in the latch whatever the direction; pins follow direction
      latch_nxt  = (ops_en_in && data_we_in) ? data_in : latch_r;
      dir_nxt    = (ops_en_in && dir_we_in) ? dir_in : dir_r;
      sample_nxt = ops_en_in ? pin_in : sample_r;
      pin_nxt    = latch_nxt;
      // Uses next values so a direction change drives on the same edge
      oe_n_nxt   = !(ops_en_nxt_in && dir_nxt);
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         // Latch content is meaningless to software until it writes one
         latch_r  <= bdp_pkg::LATCH_RST;
         sample_r <= bdp_pkg::DATA_RST;
         dir_r    <= bdp_pkg::DIR_RST;
         pin_r    <= bdp_pkg::LATCH_RST;
         oe_n_r   <= bdp_pkg::OE_N_RST;
      end
      else if (clk_en_in)
      begin
         latch_r  <= latch_nxt;
         sample_r <= sample_nxt;
         dir_r    <= dir_nxt;
         pin_r    <= pin_nxt;
         oe_n_r   <= oe_n_nxt;
      end
   end

   assign latch_out    = latch_r;
   assign sample_out   = sample_r;
   assign dir_out      = dir_r;
   assign pin_out      = pin_r;
   assign pin_oe_n_out = oe_n_r;
endmodule : bdp_port_slice

// File: verilog/bdp_irq_ctrl.sv
// Level interrupt logic: per-source polarity, per-source enable, one request
module bdp_irq_ctrl
(
   input  wire logic                      clk_in,
   input  wire logic                      reset_n_in,
   input  wire logic                      clk_en_in,
   input  wire logic                      en_we_in,
   input  wire logic [bdp_pkg::IRQ_N-1:0] en_in,
   input  wire logic                      pol_we_in,
   input  wire logic [bdp_pkg::IRQ_N-1:0] pol_in,
   input  wire logic [bdp_pkg::IRQ_N-1:0] src_in,
   output logic      [bdp_pkg::IRQ_N-1:0] en_out,
   output logic      [bdp_pkg::IRQ_N-1:0] pol_out,
   output logic      [bdp_pkg::IRQ_N-1:0] level_out,
   output logic                           irq_out
);
   logic [bdp_pkg::IRQ_N-1:0] en_r, en_nxt;
   logic [bdp_pkg::IRQ_N-1:0] pol_r, pol_nxt;
   logic [bdp_pkg::IRQ_N-1:0] level_r, level_nxt;
   logic                      irq_r, irq_nxt;

   always_comb
   begin
      en_nxt    = en_we_in ? en_in : en_r;
      pol_nxt   = pol_we_in ? pol_in : pol_r;
      level_nxt = src_in ^ pol_r;
      // No edge memory: request simply follows the adjusted levels
      irq_nxt   = |((src_in ^ pol_r) & en_r);
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         en_r    <= bdp_pkg::IRQ_EN_RST;
         pol_r   <= bdp_pkg::IRQ_POL_RST;
         level_r <= '0;
         irq_r   <= 1'b0;
      end
      else if (clk_en_in)
      begin
         en_r    <= en_nxt;
         pol_r   <= pol_nxt;
         level_r <= level_nxt;
         irq_r   <= irq_nxt;
      end
   end

   assign en_out    = en_r;
   assign pol_out   = pol_r;
   assign level_out = level_r;
   assign irq_out   = irq_r;
endmodule : bdp_irq_ctrl

// File: sim/bdp_field_model.sv
// Field-side model: external TTL sources sharing the port pins
module bdp_field_model
#(
   parameter int NUM_PORTS = 18
)
(
   input  wire logic [NUM_PORTS*bdp_pkg::PORT_W-1:0] ext_level_in,
   input  wire logic [NUM_PORTS*bdp_pkg::PORT_W-1:0] pin_out_in,
   input  wire logic [NUM_PORTS-1:0]                 pin_oe_n_in,
   output logic      [NUM_PORTS*bdp_pkg::PORT_W-1:0] pin_level_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ***************************************************************
   // Wire level per port
   // ***************************************************************
   // Field sources back off while the port drives; contention not modelled
   always_comb
   begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         pin_level_out[p*8 +: 8] = pin_oe_n_in[p] ? ext_level_in[p*8 +: 8] : pin_out_in[p*8 +: 8];
      end
   end
endmodule : bdp_field_model

// File: sim/bdp_dio_top_tb.sv
// Self-checking bench for the banked digital I/O block
module bdp_dio_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NP = 18;
   logic            core_clk_in = 0, reset_n_in = 0, clk_en_in = 1;
   logic            ops_en_we_in = 0, ops_en_in = 0, data_we_in = 0, data_re_in = 0;
   logic            dir_we_in = 0, irq_en_we_in = 0, irq_pol_we_in = 0;
   logic [4:0]      port_sel_in = 0;
   logic [7:0]      data_in = 0;
   logic [NP-1:0]   dir_in = 0, dir_out, pin_oe_n_out, dir_m;
   logic [3:0]      irq_en_in = 0, irq_pol_in = 0, irq_level_out, en_m, pol_m;
   logic [NP*8-1:0] pin_in, pin_out, ext_lv = 0;
   logic [7:0]      rdata_out, lat_m [NP];
   logic            ops_en_out, rvalid_out, irq_out, ops_m;
   int              failures = 0, check_count = 0, seed = 72721;
   // ***************************************************************
   // Clock, design and field
   // ***************************************************************
   always #5 core_clk_in = ~core_clk_in;
   bdp_dio_top #(.NUM_PORTS(NP)) DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .clk_en_in(clk_en_in), .ops_en_we_in(ops_en_we_in), .ops_en_in(ops_en_in),
      .ops_en_out(ops_en_out), .port_sel_in(port_sel_in), .data_we_in(data_we_in),
      .data_in(data_in), .data_re_in(data_re_in), .rdata_out(rdata_out),
      .rvalid_out(rvalid_out), .dir_we_in(dir_we_in), .dir_in(dir_in), .dir_out(dir_out),
      .irq_en_we_in(irq_en_we_in), .irq_en_in(irq_en_in), .irq_pol_we_in(irq_pol_we_in),
      .irq_pol_in(irq_pol_in), .irq_level_out(irq_level_out), .irq_out(irq_out),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out));
   bdp_field_model #(.NUM_PORTS(NP)) field (.ext_level_in(ext_lv), .pin_out_in(pin_out),
      .pin_oe_n_in(pin_oe_n_out), .pin_level_out(pin_in));
   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic tick(int n = 1);
      repeat (n)
      begin
         @(posedge core_clk_in);
         #1;
      end
   endtask : tick
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   // Each strobe is followed by one idle edge, so no signal moves twice per step
   task automatic wr(logic [4:0] s, logic [7:0] d);
      port_sel_in = s;
      data_in = d;
      data_we_in = 1;
      if (ops_m && clk_en_in && s < NP)
         lat_m[s] = d;
      tick();
      data_we_in = 0;
      tick();
   endtask : wr
   task automatic set_ops(logic v);
      ops_en_in = v;
      ops_en_we_in = 1;
      tick();
      ops_en_we_in = 0;
      ops_m = v;
      chk(ops_en_out, v);
      tick();
   endtask : set_ops
   task automatic set_dir(logic [NP-1:0] d);
      dir_in = d;
      dir_we_in = 1;
      if (ops_m)
         dir_m = d;
      tick();
      dir_we_in = 0;
      tick();
   endtask : set_dir
   task automatic set_irq(logic [3:0] e, logic [3:0] pl);
      irq_en_in = e;
      irq_pol_in = pl;
      irq_en_we_in = 1;
      irq_pol_we_in = 1;
      en_m = e;
      pol_m = pl;
      tick();
      irq_en_we_in = 0;
      irq_pol_we_in = 0;
      tick();
   endtask : set_irq
   task automatic rd(logic [4:0] s);
      logic [7:0] exp;
      exp = 8'h00;
      if (ops_m && s < NP)
         exp = dir_m[s] ? lat_m[s] : ext_lv[s*8 +: 8];
      port_sel_in = s;
      data_re_in = 1;
      tick();
      data_re_in = 0;
      chk(rvalid_out, 1'b1);
      chk(rdata_out, exp);
      tick();
      chk(rvalid_out, 1'b0);
   endtask : rd
   task automatic chk_pins();
      chk(dir_out, dir_m);
      for (int p = 0; p < NP; p++)
      begin
         chk(pin_oe_n_out[p], !(ops_m && dir_m[p]));
         if (ops_m && dir_m[p])
            chk(pin_out[p*8 +: 8], lat_m[p]);
      end
   endtask : chk_pins
   task automatic chk_irq();
      logic [3:0] lvl;
      lvl = ext_lv[bdp_pkg::IRQ_PORT*8 +: 4];
      if (ops_m && dir_m[bdp_pkg::IRQ_PORT])
         lvl = lat_m[bdp_pkg::IRQ_PORT][3:0];
      lvl = lvl ^ pol_m;
      chk(irq_level_out, lvl);
      chk(irq_out, |(lvl & en_m));
   endtask : chk_irq
   task automatic model_reset();
      ops_m = 0;
      dir_m = '0;
      en_m = 4'h0;
      pol_m = 4'h0;
   endtask : model_reset
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      model_reset();
      foreach (lat_m[p])
         lat_m[p] = 8'h00;
      repeat (2) @(posedge core_clk_in);
      #1 reset_n_in = 1;
      chk(ops_en_out, 1'b0);
      chk_pins();
      tick(2);
      chk_irq();
      // Disabled: writes, directions and reads refused
      wr(1, 8'ha5);
      set_dir('1);
      chk_pins();
      rd(1);
      set_ops(1'b1);
      for (int p = 0; p < NP; p++)
      begin
         wr(p[4:0], 8'($random(seed)));
         ext_lv[p*8 +: 8] = 8'($random(seed));
         chk_pins();
      end
      wr(5'd20, 8'h3c);
      for (int p = 0; p < NP; p++)
         rd(p[4:0]);
      repeat (4)
      begin
         set_dir(NP'($random(seed)));
         chk_pins();
         wr(5'($unsigned($random(seed)) % NP), 8'($random(seed)));
         chk_pins();
         for (int p = 0; p < NP; p++)
            rd(p[4:0]);
         rd(5'd20);
      end
      // Disable mid-run: pins float, directions kept, writes dropped
      set_dir('1);
      set_ops(1'b0);
      chk_pins();
      wr(5'd0, 8'h77);
      rd(5'd0);
      set_ops(1'b1);
      chk_pins();
      rd(5'd0);
      // Frozen clock enable drops a write
      clk_en_in = 0;
      wr(5'd4, 8'h99);
      clk_en_in = 1;
      tick();
      rd(5'd4);
      // Every enable and polarity code, random source levels
      set_dir('0);
      for (int k = 0; k < 256; k++)
      begin
         ext_lv[bdp_pkg::IRQ_PORT*8 +: 4] = 4'($random(seed));
         set_irq(k[3:0], k[7:4]);
         tick(2);
         chk_irq();
      end
      // Handler flow: sources held, active ones flipped
      ext_lv[bdp_pkg::IRQ_PORT*8 +: 4] = 4'h5;
      set_irq(4'hf, 4'h0);
      tick(2);
      chk_irq();
      rd(5'd2);
      set_irq(4'hf, 4'h5);
      tick(2);
      chk_irq();
      set_dir(NP'(4));
      tick(2);
      chk_irq();
      // Second reset in mid-run
      reset_n_in = 0;
      model_reset();
      tick();
      chk(irq_level_out, 4'h0);
      chk(irq_out, 1'b0);
      reset_n_in = 1;
      tick();
      chk(ops_en_out, 1'b0);
      chk_pins();
      tick(2);
      chk_irq();
      end_sim();
   end
   initial
   begin
      #900000;
      failures++;
      end_sim();
   end
endmodule : bdp_dio_top_tb
